// *** logic/tofm_consts.svh ***
// Constants for the time-of-flight timebase and marker block
`ifndef TOFM_CONSTS_SVH
`define TOFM_CONSTS_SVH

// Register byte addresses; the rate register sits at word index 9, four bytes per word
`define TOFM_IDX_CLOCK_RATE 12'h009
`define TOFM_ADDR_CLOCK_RATE 12'h024
`define TOFM_ADDR_CONTROL 12'h100
`define TOFM_ADDR_STATUS 12'h104
`define TOFM_ADDR_BURST 12'h108

// Field positions and reset values
`define TOFM_RST_CLOCK_RATE 8'h00
`define TOFM_BIT_DIV 2
`define TOFM_RST_PULSES 5'h05
`define TOFM_RST_ARRIVALS 3'h1
`define TOFM_BIT_START 0
`define TOFM_BIT_ABORT 1
`define TOFM_BIT_RX_EN 2

// Auto-zero base count for code 0 (64 base periods), doubled per code step
`define TOFM_AZ_BASE 10'h040
// Half a burst cycle in base periods
`define TOFM_HALF_PER 8'h04
// Arrival marker width in clock cycles
`define TOFM_MARK_LEN 4'h4

// AXI responses
`define TOFM_RESP_OKAY 2'h0
`define TOFM_RESP_SLVERR 2'h2

`endif

// *** logic/tofm_pkg.sv ***
// Types for the time-of-flight timebase and marker block
package tofm_pkg;
    typedef enum logic [2:0] {
        TOFM_IDLE = 3'h0,
        TOFM_TX = 3'h1,
        TOFM_AZ = 3'h3,
        TOFM_RX = 3'h2,
        TOFM_DONE = 3'h6
    } tofm_state_t;
endpackage

// *** logic/tofm_tick_if.sv ***
// Base period tick carrier between the top and the timebase
`timescale 1ns/1ps
interface tofm_tick_if;
    logic div_sel;
    logic tick;
    modport src (input div_sel, output tick);
    modport dst (output div_sel, input tick);
endinterface

// *** logic/tofm_timebase.sv ***
// Base period tick generator: reference clock divided by one or two
`timescale 1ns/1ps
module tofm_timebase (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Tick carrier
    tofm_tick_if.src tb
);
    typedef struct packed {
        logic phase;
    } tofm_tb_st_t;

    tofm_tb_st_t s_q, s_d;

    // Divide by two toggles a phase bit; divide by one ticks every cycle
    always_comb begin
        s_d = s_q;
        s_d.phase = tb.div_sel ? ~s_q.phase : 1'b0;
    end

    assign tb.tick = ce & (~tb.div_sel | s_q.phase);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
endmodule // tofm_timebase

// *** logic/tofm_top.sv ***
// Time-of-flight timebase, transducer routing and launch/arrival markers
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tofm_consts.svh"
module tofm_top (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive comparator input
    input wire logic echo_valid,
    // Transducer routing and drive
    output logic tx_route,
    output logic rx_route,
    output logic tx_drive,
    output logic autozero_active,
    // Markers to the external timer
    output logic launch_marker,
    output logic arrival_marker
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [11:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] clock_rate;
        logic [4:0] pulses;
        logic [2:0] arrivals;
        logic rx_en;
        logic start_pend;
        tofm_pkg::tofm_state_t st;
        logic [9:0] cnt;
        logic [7:0] half_cnt;
        logic [5:0] edges;
        logic [2:0] arr_seen;
        logic [3:0] mark_cnt;
        logic tx_route;
        logic rx_route;
        logic tx_drive;
        logic az;
        logic launch;
        logic arrival;
        logic echo_q;
        logic done_flag;
    } tofm_st_t;

    tofm_st_t s_q, s_d;
    tofm_tick_if tb_if ();
    logic tick;

    // Auto-zero length in base periods from the two-bit code
    function automatic logic [9:0] az_len(input logic [1:0] code);
        az_len = `TOFM_AZ_BASE << code;
    endfunction

    // Known-address check, shared by read and write decode
    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a == `TOFM_ADDR_CLOCK_RATE) || (a == `TOFM_ADDR_CONTROL) ||
                  (a == `TOFM_ADDR_STATUS) || (a == `TOFM_ADDR_BURST);
    endfunction

    assign tb_if.div_sel = s_q.clock_rate[`TOFM_BIT_DIV];
    assign tick = tb_if.tick;

    tofm_timebase u_tb (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .tb(tb_if.src)
    );

    // Register bus, measurement sequencer and markers
    always_comb begin
        s_d = s_q;
        s_d.echo_q = echo_valid;
        // Write channel: accept address and data in either order
        if (s_q.awready && s_axi_awvalid) begin
            s_d.awready = 1'b0;
            s_d.aw_got = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_q.wready && s_axi_wvalid) begin
            s_d.wready = 1'b0;
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = addr_ok(s_q.aw_addr) ? `TOFM_RESP_OKAY : `TOFM_RESP_SLVERR;
            if (s_q.w_strb[0]) begin
                case (s_q.aw_addr)
                    `TOFM_ADDR_CLOCK_RATE: begin
                        s_d.clock_rate = s_q.w_data[7:0];
                    end
                    `TOFM_ADDR_CONTROL: begin
                        s_d.rx_en = s_q.w_data[`TOFM_BIT_RX_EN];
                        if (s_q.w_data[`TOFM_BIT_START]) begin
                            s_d.start_pend = 1'b1;
                        end
                        if (s_q.w_data[`TOFM_BIT_ABORT]) begin
                            s_d.start_pend = 1'b0;
                            s_d.st = tofm_pkg::TOFM_IDLE;
                        end
                    end
                    `TOFM_ADDR_BURST: begin
                        s_d.pulses = s_q.w_data[4:0];
                        s_d.arrivals = s_q.w_data[10:8];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end
        // Read channel: one read at a time, answer one cycle after take
        if (s_q.arready && s_axi_arvalid) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = addr_ok(s_axi_araddr) ? `TOFM_RESP_OKAY : `TOFM_RESP_SLVERR;
            case (s_axi_araddr)
                `TOFM_ADDR_CLOCK_RATE: s_d.rdata = {24'h000000, s_q.clock_rate};
                `TOFM_ADDR_CONTROL: s_d.rdata = {29'h0, s_q.rx_en, 1'b0, s_q.start_pend};
                `TOFM_ADDR_STATUS: s_d.rdata = {21'h0, s_q.arr_seen, 4'h0,
                                               s_q.done_flag, s_q.st};
                `TOFM_ADDR_BURST: s_d.rdata = {21'h0, s_q.arrivals, 3'h0, s_q.pulses};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end
        // Arrival marker width counter, in clock cycles
        if (s_q.mark_cnt != 4'h0) begin
            s_d.mark_cnt = s_q.mark_cnt - 4'h1;
        end
        s_d.arrival = (s_d.mark_cnt != 4'h0);
        // Sequencer; timers advance only on base-period ticks
        case (s_q.st)
            tofm_pkg::TOFM_IDLE: begin
                s_d.tx_route = 1'b0;
                s_d.rx_route = 1'b0;
                s_d.tx_drive = 1'b0;
                s_d.launch = 1'b0;
                // Auto-zero drops too, in case an abort forced the state back
                s_d.az = 1'b0;
                if (s_q.start_pend && tick) begin
                    s_d.start_pend = 1'b0;
                    s_d.done_flag = 1'b0;
                    s_d.arr_seen = 3'h0;
                    s_d.st = tofm_pkg::TOFM_TX;
                    s_d.tx_route = 1'b1;
                    s_d.tx_drive = 1'b1;
                    s_d.launch = 1'b1;
                    s_d.half_cnt = `TOFM_HALF_PER;
                    // Two edges per burst cycle; six bits so a 31-cycle burst fits
                    s_d.edges = {s_q.pulses, 1'b0} - 6'h1;
                end
            end
            tofm_pkg::TOFM_TX: begin
                if (tick) begin
                    if (s_q.half_cnt == 8'h1) begin
                        s_d.half_cnt = `TOFM_HALF_PER;
                        if (s_q.edges == 6'h0) begin
                            s_d.tx_drive = 1'b0;
                            s_d.launch = 1'b0;
                            s_d.tx_route = 1'b0;
                            s_d.st = tofm_pkg::TOFM_AZ;
                            s_d.az = 1'b1;
                            s_d.cnt = az_len(s_q.clock_rate[1:0]);
                        end else begin
                            s_d.edges = s_q.edges - 6'h1;
                            s_d.tx_drive = ~s_q.tx_drive;
                        end
                    end else begin
                        s_d.half_cnt = s_q.half_cnt - 8'h1;
                    end
                end
            end
            tofm_pkg::TOFM_AZ: begin
                if (tick) begin
                    if (s_q.cnt == 10'h1) begin
                        s_d.az = 1'b0;
                        s_d.st = tofm_pkg::TOFM_RX;
                        s_d.rx_route = s_q.rx_en;
                    end else begin
                        s_d.cnt = s_q.cnt - 10'h1;
                    end
                end
            end
            tofm_pkg::TOFM_RX: begin
                if (!s_q.rx_route) begin
                    s_d.st = tofm_pkg::TOFM_DONE;
                end else if (echo_valid && !s_q.echo_q && s_q.mark_cnt == 4'h0) begin
                    s_d.mark_cnt = `TOFM_MARK_LEN;
                    s_d.arrival = 1'b1;
                    s_d.arr_seen = s_q.arr_seen + 3'h1;
                    if (s_q.arr_seen + 3'h1 >= s_q.arrivals) begin
                        s_d.st = tofm_pkg::TOFM_DONE;
                    end
                end
            end
            tofm_pkg::TOFM_DONE: begin
                s_d.rx_route = 1'b0;
                s_d.done_flag = 1'b1;
                s_d.st = tofm_pkg::TOFM_IDLE;
            end
            default: begin
                s_d.st = tofm_pkg::TOFM_IDLE;
            end
        endcase
        // Abort wins over a sequencer step in the same cycle, so no route or
        // launch marker is left standing when software cancels a measurement mid-way
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid && s_q.w_strb[0] &&
            s_q.aw_addr == `TOFM_ADDR_CONTROL && s_q.w_data[`TOFM_BIT_ABORT]) begin
            s_d.st = tofm_pkg::TOFM_IDLE;
            s_d.tx_route = 1'b0;
            s_d.rx_route = 1'b0;
            s_d.tx_drive = 1'b0;
            s_d.launch = 1'b0;
            s_d.az = 1'b0;
        end
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.clock_rate <= `TOFM_RST_CLOCK_RATE;
            s_q.pulses <= `TOFM_RST_PULSES;
            s_q.arrivals <= `TOFM_RST_ARRIVALS;
            s_q.rx_en <= 1'b1;
            s_q.st <= tofm_pkg::TOFM_IDLE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign tx_route = s_q.tx_route;
    assign rx_route = s_q.rx_route;
    assign tx_drive = s_q.tx_drive;
    assign autozero_active = s_q.az;
    assign launch_marker = s_q.launch;
    assign arrival_marker = s_q.arrival;
endmodule // tofm_top

// *** dv/tofm_stopwatch.sv ***
// Stopwatch model that times launch to each arrival marker
`timescale 1ns/1ps
module tofm_stopwatch (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Markers from the block
    input wire logic launch_marker,
    input wire logic arrival_marker,
    // Arrivals seen and latest flight time in cycles
    output logic [31:0] count,
    output logic [31:0] tof
);
    logic [31:0] t_q;
    logic l_q;
    logic a_q;
    // Edge detect on both markers; the timer restarts at each launch
    always_ff @(posedge sys_clk) begin
        l_q <= launch_marker;
        a_q <= arrival_marker;
        t_q <= (launch_marker && !l_q) ? 32'h0 : t_q + 32'h1;
        if (rst || (launch_marker && !l_q)) begin
            count <= 32'h0;
        end else if (arrival_marker && !a_q) begin
            count <= count + 32'h1;
            tof <= t_q;
        end
    end
endmodule // tofm_stopwatch

// *** dv/tofm_top_props.sv ***
// Port-level checker for the time-of-flight marker block
`timescale 1ns/1ps
module tofm_top_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input wire logic echo_valid,
    input wire logic tx_route,
    input wire logic rx_route,
    input wire logic tx_drive,
    input wire logic autozero_active,
    input wire logic launch_marker,
    input wire logic arrival_marker
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [10:0] az_q;
    // Length of the current auto-zero interval in cycles
    always_ff @(posedge sys_clk) begin
        az_q <= (rst || !autozero_active) ? 11'h000 : az_q + 11'h001;
    end
    a_launch_starts_tx: assert property ($rose(launch_marker) |-> tx_route && tx_drive)
        else $error("launch without transmit");
    a_burst_on_tx: assert property (launch_marker |-> tx_route && !rx_route)
        else $error("burst off transmit channel");
    a_route_exclusive: assert property (!(tx_route && rx_route))
        else $error("both routes on");
    a_az_after_burst: assert property ($fell(launch_marker) |-> ##[0:2] autozero_active)
        else $error("no auto-zero after burst");
    a_az_length: assert property ($fell(autozero_active) |-> az_q >= 11'h040 && az_q <= 11'h400)
        else $error("auto-zero length out of range");
    a_rx_after_az: assert property ($rose(rx_route) |-> $past(autozero_active))
        else $error("receive without auto-zero");
    a_arrival_width: assert property ($rose(arrival_marker) |-> arrival_marker[*4] ##1 !arrival_marker)
        else $error("arrival width wrong");
    a_echo_marks: assert property ($rose(echo_valid) && rx_route && !arrival_marker |-> ##[1:3] arrival_marker)
        else $error("echo without arrival");
endmodule // tofm_top_props
bind tofm_top tofm_top_props tofm_top_props_i (.sys_clk(sys_clk), .rst(rst),
    .echo_valid(echo_valid), .tx_route(tx_route), .rx_route(rx_route), .tx_drive(tx_drive),
    .autozero_active(autozero_active), .launch_marker(launch_marker),
    .arrival_marker(arrival_marker));

// *** dv/tb_top.sv ***
// Self-checking bench for the time-of-flight timebase and marker block
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;
        logic [1:0] r;} tofm_row_t;
    logic sys_clk = 1'b0, rst = 1'b1, echo_valid = 1'b0, ce = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, tm_count, tm_tof;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic tx_route, rx_route, tx_drive, autozero_active, launch_marker, arrival_marker;
    logic [31:0] d;
    int mismatches = 0, checked = 0, cyc = 0;
    // Register traffic: strobe-ignored write, unmapped slot, read-back
    tofm_row_t rows [5] = '{'{12'h024, 32'h1ff, 4'hf, 32'hff, 2'h0},
        '{12'h024, 32'h3, 4'he, 32'hff, 2'h0}, '{12'h028, 32'h1, 4'hf, 32'h0, 2'h2},
        '{12'h108, 32'h203, 4'hf, 32'h203, 2'h0}, '{12'h024, 32'h0, 4'hf, 32'h0, 2'h0}};

    tofm_top tofm_top_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .echo_valid(echo_valid),
        .tx_route(tx_route), .rx_route(rx_route), .tx_drive(tx_drive),
        .autozero_active(autozero_active), .launch_marker(launch_marker),
        .arrival_marker(arrival_marker));
    tofm_stopwatch tofm_stopwatch_i (.sys_clk(sys_clk), .rst(rst), .launch_marker(launch_marker),
        .arrival_marker(arrival_marker), .count(tm_count), .tof(tm_tof));

    // Clock and a hang guard; the longest run is a few thousand cycles
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Each channel is released at its own handshake edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // One measurement: burst and auto-zero lengths, then one echo more than wanted
    task automatic meas(input logic [1:0] code, input logic dv, input logic [2:0] arr,
        input logic [4:0] pul);
        int nl;
        int na;
        int ne;
        logic pd;
        wr(12'h024, {29'h0, dv, code}, 4'hf);
        wr(12'h108, {21'h0, arr, 3'h0, pul}, 4'hf);
        wr(12'h100, 32'h5, 4'hf);
        nl = 0;
        na = 0;
        ne = 0;
        pd = 1'b0;
        while (!launch_marker) @(posedge sys_clk);
        chk(tx_route, 1'b1);
        // Count burst length and drive rising edges together
        while (launch_marker) begin
            @(posedge sys_clk);
            nl++;
            if (tx_drive && !pd) ne++;
            pd = tx_drive;
        end
        chk(nl, pul * 8 * (dv + 1));
        chk(ne, pul);
        while (!autozero_active) @(posedge sys_clk);
        while (autozero_active) begin
            @(posedge sys_clk);
            na++;
        end
        chk(na, (64 << code) * (dv + 1));
        repeat (2) @(posedge sys_clk);
        chk(rx_route, 1'b1);
        repeat (arr + 1) begin
            echo_valid <= 1'b1;
            repeat (2) @(posedge sys_clk);
            echo_valid <= 1'b0;
            repeat (8) @(posedge sys_clk);
        end
        chk(tm_count, arr);
        chk(tm_tof >= nl + na, 1'b1);
        chk(rx_route, 1'b0);
        rd(12'h104);
        chk({d[10:8], d[3]}, {arr, 1'b1});
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h024);
        chk(d, 32'h0);
        rd(12'h108);
        chk(d, 32'h105);
        rd(12'h100);
        chk(d, 32'h4);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].s);
            chk(r, rows[i].r);
            rd(rows[i].a);
            chk(d, rows[i].e);
            chk(r, rows[i].r);
        end
        meas(2'h0, 1'b1, 3'h1, 5'h01);
        meas(2'h1, 1'b0, 3'h2, 5'h05);
        meas(2'h2, 1'b1, 3'h3, 5'h1f);
        meas(2'h3, 1'b0, 3'h2, 5'h02);
        // Freeze inside the burst, then abort while listening with no echo pending
        wr(12'h100, 32'h5, 4'hf);
        while (!launch_marker) @(posedge sys_clk);
        ce <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk(launch_marker, 1'b1);
        ce <= 1'b1;
        while (!rx_route) @(posedge sys_clk);
        wr(12'h100, 32'h6, 4'hf);
        repeat (4) @(posedge sys_clk);
        chk(rx_route, 1'b0);
        // Mid-run reset brings the configuration back to its defaults
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(12'h024);
        chk(d, 32'h0);
        rd(12'h108);
        chk(d, 32'h105);
        summarize();
    end
endmodule // tb_top
